// file: pkg/urm_pkg.sv
// Constants and types shared by the mute-capable serial receiver
package urm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MUTE = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // Control register fields
  localparam int CTRL_RXEN_BIT   = 0;
  localparam int CTRL_WAKE_BIT   = 1;
  localparam int CTRL_LONG_BIT   = 2;
  localparam int CTRL_OVERSAMPLE_BY_EIGHT_SELECT_BIT  = 3;
  localparam int CTRL_SINGLE_BIT = 4;
  localparam int CTRL_NODE_LSB   = 8;
  localparam int NODE_W          = 4;

  // Mute register fields
  localparam int MUTE_FLAG_BIT = 0;
  localparam int MUTE_RECEIVE_NOT_EMPTY_FLAG_BIT = 1;

  // Sticky status and mask layout
  localparam int ST_RX   = 0;
  localparam int ST_IDLE = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVR  = 3;
  localparam int ST_W    = 4;

  // Widths and reset values
  localparam int              BAUD_W    = 16;
  localparam logic [15:0]     BAUD_RST  = 16'h0000;
  localparam logic [ST_W-1:0] MASK_RST  = 4'h0;
  localparam logic [0:0]      LINE_IDLE = 1'h1;

  // Sample ticks per bit, bit times per character and data bits per character
  localparam logic [4:0] OS_SIXTEEN  = 5'h10;
  localparam logic [4:0] OS_EIGHT    = 5'h08;
  localparam logic [3:0] FRAME_SHORT = 4'ha;
  localparam logic [3:0] FRAME_LONG  = 4'hb;
  localparam logic [3:0] DATA_SHORT  = 4'h8;
  localparam logic [3:0] DATA_LONG   = 4'h9;

  typedef enum logic [1:0] {
    URM_IDLE,
    URM_START,
    URM_DATA,
    URM_STOP
  } urm_rx_e;
endpackage : urm_pkg

// file: hdl/urm_sync3.sv
// Three-flop synchroniser for the receive pin
`timescale 1ns/1ps
`default_nettype none
module urm_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output var  logic o_q
);
  typedef struct packed {
    logic [2:0] ff;
    logic       q;
  } urm_sync_s;

  urm_sync_s s_r;
  urm_sync_s s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.ff = {s_r.ff[1:0], i_d};
    // Stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
    if (s_r.ff[1] == s_r.ff[2]) begin
      s_nxt.q = s_r.ff[2];
    end
  end

  // Line idles high, so reset to ones to avoid a false start
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;
endmodule : urm_sync3
`default_nettype wire

// file: hdl/urm_rx.sv
// Serial receiver with mute and wakeup, AHB-Lite registers and interrupt
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Muted receiver sets no status flag
// - Muted receiver raises no receive interrupt
// - Wake select: idle line or address mark
// - Idle mode: software writing one mutes
// - Idle mode: idle frame wakes and clears mute flag
// - Waking idle frame sets no idle flag
// - Idle mode: software writing zero unmutes
// - Long word gives eleven bit times
// - Oversample sixteen or eight per bit
// - Bit decided from one or three samples
// - Centre sampling gives integer divider tolerance
// - Same sampling holds fractional divider tolerance
// - Idle frame is ten or eleven bits
// - Address character: msb set, low nibble compared
// - Matching address unmutes and fills buffer
// - Mute writes ignored while buffer full
module urm_rx (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output var  logic [31:0] o_hrdata,
  output var  logic        o_hreadyout,
  output var  logic        o_hresp,
  input  wire logic        i_rx,
  output var  logic        o_irq
);
  typedef struct packed {
    logic                     rx_en;
    logic                     wake;
    logic                     long_w;
    logic                     oversample_by_eight_select;
    logic                     single;
    logic [urm_pkg::NODE_W-1:0] node;
    logic [urm_pkg::BAUD_W-1:0] baud;
    logic                     mute;
    logic                     receive_not_empty_flag;
    logic [8:0]               data;
    logic [urm_pkg::ST_W-1:0] stat;
    logic [urm_pkg::ST_W-1:0] mask;
    logic                     ph_act;
    logic                     ph_wr;
    logic                     rd_wait;
    logic [7:0]               ph_addr;
    logic [31:0]              hrdata;
    urm_pkg::urm_rx_e         rx_st;
    logic [urm_pkg::BAUD_W-1:0] div_cnt;
    logic [4:0]               sc;
    logic [3:0]               bit_idx;
    logic [8:0]               shift;
    logic [2:0]               smp;
    logic [7:0]               idle_cnt;
    logic                     idle_done;
  } urm_state_s;

  urm_state_s s_r;
  urm_state_s s_nxt;

  logic                     rx_s;
  logic                     tick;
  logic [4:0]               os;
  logic [4:0]               half;
  logic [3:0]               frame;
  logic [3:0]               nbits;
  logic [7:0]               idle_len;
  logic                     bitval;
  logic                     wr;
  logic                     rd;
  logic                     mute_wr;
  logic                     receive_not_empty_flag_clr;
  logic                     char_done;
  logic                     idle_hit;
  logic [8:0]               char_data;
  logic                     is_addr;
  logic                     match;
  logic                     deliver;
  logic [urm_pkg::ST_W-1:0] st_set;

  urm_sync3 u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_rx),
    .o_q   (rx_s)
  );

  // Frame shape from the format selects
  assign os       = s_r.oversample_by_eight_select ? urm_pkg::OS_EIGHT : urm_pkg::OS_SIXTEEN;
  assign half     = {1'h0, os[4:1]};
  assign frame    = s_r.long_w ? urm_pkg::FRAME_LONG : urm_pkg::FRAME_SHORT;
  assign nbits    = s_r.long_w ? urm_pkg::DATA_LONG : urm_pkg::DATA_SHORT;
  assign idle_len = 8'(8'(frame) * 8'(os) - 8'h01);
  // Middle sample alone, or majority of three around the bit centre
  assign bitval   = s_r.single ? s_r.smp[1] :
                    ((s_r.smp[0] & s_r.smp[1]) | (s_r.smp[1] & s_r.smp[2]) |
                     (s_r.smp[0] & s_r.smp[2]));
  assign tick     = (s_r.div_cnt == s_r.baud);

  // Bus phases: writes finish in one data cycle, reads take one wait
  assign wr       = s_r.ph_act & s_r.ph_wr;
  assign rd       = s_r.ph_act & ~s_r.ph_wr & s_r.rd_wait;
  assign mute_wr  = wr & (s_r.ph_addr == urm_pkg::ADDR_MUTE);
  assign receive_not_empty_flag_clr = rd & (s_r.ph_addr == urm_pkg::ADDR_DATA);

  // Eight-bit data sits in the top of the shifter; the msb is bit 8 either way
  assign char_data = s_r.long_w ? s_r.shift : {1'h0, s_r.shift[8:1]};
  assign is_addr   = s_r.wake & s_r.shift[8];
  assign match     = (char_data[urm_pkg::NODE_W-1:0] == s_r.node);

  always_comb begin
    s_nxt     = s_r;
    char_done = 1'h0;
    idle_hit  = 1'h0;
    deliver   = 1'h0;
    st_set    = '0;

    s_nxt.div_cnt = tick ? '0 : s_r.div_cnt + 16'h0001;

    // Receive sequencer, stepped once per sample tick
    if (!s_r.rx_en) begin
      s_nxt.rx_st    = urm_pkg::URM_IDLE;
      s_nxt.idle_cnt = '0;
    end else if (tick) begin
      unique case (s_r.rx_st)
        urm_pkg::URM_IDLE: begin
          if (!rx_s) begin
            s_nxt.rx_st     = urm_pkg::URM_START;
            s_nxt.sc        = '0;
            s_nxt.idle_cnt  = '0;
            s_nxt.idle_done = 1'h0;
          end else if (!s_r.idle_done) begin
            if (s_r.idle_cnt == idle_len) begin
              idle_hit        = 1'h1;
              s_nxt.idle_done = 1'h1;
              s_nxt.idle_cnt  = '0;
            end else begin
              s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
            end
          end
        end
        urm_pkg::URM_START, urm_pkg::URM_DATA: begin
          s_nxt.sc = s_r.sc + 5'h01;
          if ((s_r.sc >= half - 5'h01) && (s_r.sc <= half + 5'h01)) begin
            s_nxt.smp = {s_r.smp[1:0], rx_s};
          end
          if (s_r.sc == os - 5'h01) begin
            s_nxt.sc = '0;
            if (s_r.rx_st == urm_pkg::URM_START) begin
              // A high start bit is noise; go back to hunting
              s_nxt.rx_st   = bitval ? urm_pkg::URM_IDLE : urm_pkg::URM_DATA;
              s_nxt.bit_idx = '0;
            end else begin
              s_nxt.shift   = {bitval, s_r.shift[8:1]};
              s_nxt.bit_idx = s_r.bit_idx + 4'h1;
              if (s_r.bit_idx == nbits - 4'h1) begin
                s_nxt.rx_st = urm_pkg::URM_STOP;
              end
            end
          end
        end
        urm_pkg::URM_STOP: begin
          s_nxt.sc = s_r.sc + 5'h01;
          if ((s_r.sc >= half - 5'h01) && (s_r.sc <= half + 5'h01)) begin
            s_nxt.smp = {s_r.smp[1:0], rx_s};
          end
          // Finish at mid stop bit so a following start edge is not missed
          if (s_r.sc == half + 5'h02) begin
            char_done      = 1'h1;
            s_nxt.rx_st    = urm_pkg::URM_IDLE;
            s_nxt.idle_cnt = '0;
          end
        end
      endcase
    end

    // Bus address phase
    if (i_hsel && i_htrans[1] && i_hready) begin
      s_nxt.ph_act  = 1'h1;
      s_nxt.ph_wr   = i_hwrite;
      s_nxt.rd_wait = ~i_hwrite;
      s_nxt.ph_addr = i_haddr[7:0];
    end else if (i_hready) begin
      s_nxt.ph_act = 1'h0;
    end

    // Read data is registered in the wait cycle; unmapped reads return zero
    if (rd) begin
      s_nxt.rd_wait = 1'h0;
      unique case (s_r.ph_addr)
        urm_pkg::ADDR_CTRL: s_nxt.hrdata = {20'h0_0000, s_r.node, 3'h0, s_r.single,
                                            s_r.oversample_by_eight_select, s_r.long_w, s_r.wake, s_r.rx_en};
        urm_pkg::ADDR_MUTE: s_nxt.hrdata = {30'h0000_0000, s_r.receive_not_empty_flag, s_r.mute};
        urm_pkg::ADDR_BAUD: s_nxt.hrdata = {16'h0000, s_r.baud};
        urm_pkg::ADDR_DATA: s_nxt.hrdata = {23'h00_0000, s_r.data};
        urm_pkg::ADDR_STAT: s_nxt.hrdata = {28'h000_0000, s_r.stat};
        urm_pkg::ADDR_MASK: s_nxt.hrdata = {28'h000_0000, s_r.mask};
        default:            s_nxt.hrdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (s_r.ph_addr)
        urm_pkg::ADDR_CTRL: begin
          s_nxt.rx_en  = i_hwdata[urm_pkg::CTRL_RXEN_BIT];
          s_nxt.wake   = i_hwdata[urm_pkg::CTRL_WAKE_BIT];
          s_nxt.long_w = i_hwdata[urm_pkg::CTRL_LONG_BIT];
          s_nxt.oversample_by_eight_select  = i_hwdata[urm_pkg::CTRL_OVERSAMPLE_BY_EIGHT_SELECT_BIT];
          s_nxt.single = i_hwdata[urm_pkg::CTRL_SINGLE_BIT];
          s_nxt.node   = i_hwdata[urm_pkg::CTRL_NODE_LSB +: urm_pkg::NODE_W];
        end
        urm_pkg::ADDR_MUTE: begin
          if (!s_r.receive_not_empty_flag) begin
            s_nxt.mute = i_hwdata[urm_pkg::MUTE_FLAG_BIT];
          end
        end
        urm_pkg::ADDR_BAUD: s_nxt.baud = i_hwdata[urm_pkg::BAUD_W-1:0];
        urm_pkg::ADDR_STAT: s_nxt.stat = s_r.stat & ~i_hwdata[urm_pkg::ST_W-1:0];
        urm_pkg::ADDR_MASK: s_nxt.mask = i_hwdata[urm_pkg::ST_W-1:0];
        default: ;
      endcase
    end
    if (receive_not_empty_flag_clr) begin
      s_nxt.receive_not_empty_flag = 1'h0;
    end

    // Idle frame: wakes an idle-mode mute, else reports idle unless muted
    if (idle_hit) begin
      if (s_r.mute && !s_r.wake) begin
        s_nxt.mute = 1'h0;
      end else if (!s_r.mute) begin
        st_set[urm_pkg::ST_IDLE] = 1'h1;
      end
    end

    // Character end: address filtering, then delivery to the buffer
    if (char_done) begin
      if (is_addr) begin
        s_nxt.mute = ~match;
        deliver    = match;
      end else begin
        deliver = ~s_r.mute;
      end
    end
    if (deliver) begin
      st_set[urm_pkg::ST_FERR] = ~bitval;
      // A full buffer keeps the older character and flags the loss
      if (s_r.receive_not_empty_flag && !receive_not_empty_flag_clr) begin
        st_set[urm_pkg::ST_OVR] = 1'h1;
      end else begin
        s_nxt.data             = char_data;
        s_nxt.receive_not_empty_flag             = 1'h1;
        st_set[urm_pkg::ST_RX] = 1'h1;
      end
    end
    // Set wins over a same-cycle clear
    s_nxt.stat = s_nxt.stat | st_set;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_hrdata    = s_r.hrdata;
  assign o_hreadyout = ~rd;
  assign o_hresp     = 1'h0;
  assign o_irq       = ~s_r.mute & (|(s_r.stat & s_r.mask));

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_MUTED_NO_RECEIVE_NOT_EMPTY_FLAG: assert property (
    (s_r.mute && !(is_addr && match)) |=> !$rose(s_r.receive_not_empty_flag))
    else $error("Buffer filled while muted");
  AST_MUTED_NO_STAT: assert property (
    s_r.mute && !(char_done && is_addr && match) |=> ((s_r.stat & ~$past(s_r.stat)) == '0))
    else $error("Status flag set while muted");
  AST_MUTED_NO_IRQ: assert property (
    s_r.mute |-> !o_irq)
    else $error("Interrupt raised while muted");
  AST_IDLE_MODE_DELIVERS: assert property (
    char_done && !s_r.wake && !s_r.mute && !s_r.receive_not_empty_flag && !mute_wr |=> s_r.receive_not_empty_flag && !s_r.mute)
    else $error("Idle-mode character not delivered");
  AST_MUTE_WRITE_ONE: assert property (
    mute_wr && !s_r.receive_not_empty_flag && i_hwdata[0] && !idle_hit && !char_done |=>
      s_r.mute ##1 (s_r.mute || $past(idle_hit || char_done || mute_wr)))
    else $error("Mute write of one not taken");
  AST_IDLE_WAKE: assert property (
    idle_hit && s_r.mute && !s_r.wake && !mute_wr |=> !s_r.mute)
    else $error("Idle frame did not wake");
  AST_WAKE_NO_IDLE_FLAG: assert property (
    idle_hit && s_r.mute |=> !$rose(s_r.stat[urm_pkg::ST_IDLE]))
    else $error("Idle flag set on wakeup frame");
  AST_ADDR_MATCH_WAKE: assert property (
    char_done && is_addr && match && !s_r.receive_not_empty_flag |=> !s_r.mute && s_r.receive_not_empty_flag)
    else $error("Matching address did not wake");
  AST_MUTE_WRITE_BLOCKED: assert property (
    mute_wr && s_r.receive_not_empty_flag && !idle_hit && !char_done |=> $stable(s_r.mute))
    else $error("Mute write taken with full buffer");

  COV_IDLE_WAKE:  cover property (idle_hit && s_r.mute && !s_r.wake ##1 !s_r.mute);
  COV_ADDR_WAKE:  cover property (char_done && is_addr && match && s_r.mute);
  COV_ADDR_MUTE:  cover property (char_done && is_addr && !match && !s_r.mute);
  COV_READ_WAIT:  cover property (rd ##1 o_hreadyout);
endmodule : urm_rx
`default_nettype wire

// file: bench/urm_tx_model.sv
// Remote serial sender standing on the shared receive line
`timescale 1ns/1ps
`default_nettype none
module urm_tx_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [8:0] i_data,
  input  wire logic       i_long,
  input  wire logic [7:0] i_cpb,
  output var  logic       o_tx,
  output var  logic       o_busy
);
  int n;
  // Bit length in whole clocks, so a slightly fast or slow sender is one number away
  initial begin
    o_tx = 1'h1;
    o_busy = 1'h0;
    forever begin
      do @(posedge i_clk); while (!i_go);
      o_busy <= 1'h1;
      o_tx <= 1'h0;
      repeat (i_cpb) @(posedge i_clk);
      for (n = 0; n < (i_long ? 9 : 8); n++) begin
        o_tx <= i_data[n];
        repeat (i_cpb) @(posedge i_clk);
      end
      o_tx <= 1'h1;
      repeat (i_cpb) @(posedge i_clk);
      o_busy <= 1'h0;
    end
  end
endmodule : urm_tx_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the mute-capable serial receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rx;
  logic        irq;
  logic        go = 1'h0;
  logic [8:0]  tx_data = 9'h000;
  logic        tx_long = 1'h0;
  logic [7:0]  cpb = 8'h40;
  logic        busy;
  logic [31:0] rd;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // Format table: control word and sender bit length; 63 and 65 clocks test rate deviation
  logic [31:0] cf [6] = '{32'h0000_0001, 32'h0000_0015, 32'h0000_0009,
                          32'h0000_0019, 32'h0000_0001, 32'h0000_0011};
  logic [7:0]  cp [6] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h3f, 8'h41};

  always #4 i_clk = ~i_clk;

  urm_rx u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_rx(rx), .o_irq(irq));

  urm_tx_model u_tx (.i_clk(i_clk), .i_go(go), .i_data(tx_data), .i_long(tx_long),
    .i_cpb(cpb), .o_tx(rx), .o_busy(busy));

  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Single word transfer; the address phase is held until hready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge i_clk);
    while (hready !== 1'h1) @(posedge i_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'h1) @(posedge i_clk);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'h0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic send(input logic [8:0] d);
    tx_data <= d;
    go <= 1'h1;
    @(posedge i_clk);
    go <= 1'h0;
    @(posedge i_clk);
    while (busy) @(posedge i_clk);
    repeat (6) @(posedge i_clk);
  endtask : send

  task automatic bits(input int n);
    repeat (n * cpb) @(posedge i_clk);
  endtask : bits

  task automatic t_reset;
    rdchk(urm_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl_rst");
    rdchk(urm_pkg::ADDR_MASK, 32'h0000_0000, "mask_rst");
    rdchk(urm_pkg::ADDR_BAUD, 32'h0000_0000, "baud_rst");
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0000, "mute_rst");
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    bus(1'h1, 8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0000_0000, "unmapped");
    bus(1'h1, urm_pkg::ADDR_BAUD, 32'h0000_0003);
    bus(1'h1, urm_pkg::ADDR_MASK, 32'h0000_0001);
    rdchk(urm_pkg::ADDR_BAUD, 32'h0000_0003, "baud");
  endtask : t_reset

  task automatic t_formats;
    logic [8:0] d;
    for (int i = 0; i < 6; i++) begin
      d = cf[i][2] ? 9'h15a : 9'h0a5;
      cpb <= cp[i];
      tx_long <= cf[i][2];
      bus(1'h1, urm_pkg::ADDR_CTRL, cf[i]);
      send(d);
      chk("irq_rx", {31'h0, irq}, 32'h0000_0001);
      rdchk(urm_pkg::ADDR_DATA, {23'h0, d}, "data_fmt");
      bus(1'h1, urm_pkg::ADDR_STAT, 32'h0000_000f);
      @(posedge i_clk);
      chk("irq_clr", {31'h0, irq}, 32'h0000_0000);
    end
  endtask : t_formats

  task automatic t_idle;
    cpb <= 8'h40;
    tx_long <= 1'h0;
    bus(1'h1, urm_pkg::ADDR_CTRL, 32'h0000_0001);
    send(9'h03c);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0001, "stat_rx");
    bits(7);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0001, "idle_early");
    bits(5);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0003, "idle_set");
    rdchk(urm_pkg::ADDR_DATA, 32'h0000_003c, "data_idle");
    // Long words stretch the idle frame by one bit time; the check sits between the two ends
    bus(1'h1, urm_pkg::ADDR_STAT, 32'h0000_000f);
    tx_long <= 1'h1;
    bus(1'h1, urm_pkg::ADDR_CTRL, 32'h0000_0005);
    send(9'h1c3);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0001, "stat_long");
    bits(10);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0001, "idle_long_early");
    bits(1);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0003, "idle_long_set");
    rdchk(urm_pkg::ADDR_DATA, 32'h0000_01c3, "data_long");
    tx_long <= 1'h0;
    bus(1'h1, urm_pkg::ADDR_CTRL, 32'h0000_0001);
  endtask : t_idle

  task automatic t_mute_idle;
    bus(1'h1, urm_pkg::ADDR_MASK, 32'h0000_000f);
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0001);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0001, "mute_set");
    // Status still pending and unmasked, so only the mute can hold the line low
    chk("irq_pending_muted", {31'h0, irq}, 32'h0000_0000);
    bus(1'h1, urm_pkg::ADDR_STAT, 32'h0000_000f);
    send(9'h055);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0000, "stat_muted");
    chk("irq_muted", {31'h0, irq}, 32'h0000_0000);
    bits(12);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0000, "woke");
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0000, "no_idle");
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0001);
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0000);
    send(9'h066);
    rdchk(urm_pkg::ADDR_STAT, 32'h0000_0001, "sw_unmute");
    chk("irq_unmuted", {31'h0, irq}, 32'h0000_0001);
    rdchk(urm_pkg::ADDR_DATA, 32'h0000_0066, "data_unmuted");
  endtask : t_mute_idle

  task automatic t_addr;
    bus(1'h1, urm_pkg::ADDR_CTRL, 32'h0000_0303);
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0001);
    send(9'h011);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0001, "still_muted");
    send(9'h083);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0002, "addr_woke");
    rdchk(urm_pkg::ADDR_DATA, 32'h0000_0083, "addr_data");
    send(9'h085);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0001, "addr_muted");
    send(9'h022);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0001, "dropped");
  endtask : t_addr

  task automatic t_full;
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0000);
    bus(1'h1, urm_pkg::ADDR_CTRL, 32'h0000_0001);
    send(9'h03c);
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0001);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0002, "mute_ignored");
    rdchk(urm_pkg::ADDR_DATA, 32'h0000_003c, "data_full");
    bus(1'h1, urm_pkg::ADDR_MUTE, 32'h0000_0001);
    rdchk(urm_pkg::ADDR_MUTE, 32'h0000_0001, "mute_taken");
  endtask : t_full

  // Ceiling well above the roughly eleven thousand cycles the sequence needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    t_reset();
    t_formats();
    t_idle();
    t_mute_idle();
    t_addr();
    t_full();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
